// [design/excr_pkg.sv]
// Shared constants and types for the exception cause record block
package excr_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] EXCR_OFS_CAUSE  = 8'h00;
    localparam logic [7:0] EXCR_OFS_STATUS = 8'h04;
    localparam logic [7:0] EXCR_OFS_EPC    = 8'h08;
    localparam logic [7:0] EXCR_OFS_VEC0   = 8'h10;
    localparam logic [7:0] EXCR_OFS_VEC1   = 8'h14;
    localparam logic [7:0] EXCR_OFS_VEC2   = 8'h18;
    localparam logic [7:0] EXCR_OFS_VEC3   = 8'h1c;

    // Cause field positions
    localparam int EXCR_BD_POS = 31;
    localparam int EXCR_IP_LO  = 10;
    localparam int EXCR_SW_LO  = 8;
    localparam int EXCR_EC_LO  = 2;

    // Status field positions and writable bits
    localparam int EXCR_SR_MASK_LO = 10;
    localparam int EXCR_SR_SWM_LO  = 8;
    localparam int EXCR_SR_IEC_POS = 0;
    localparam logic [31:0] EXCR_SR_WR_MASK = 32'hf07f_ff3f;

    // Reset values
    localparam logic [31:0] EXCR_SR_RESET  = 32'h0000_0000;
    localparam logic [31:0] EXCR_EPC_RESET = 32'h0000_0000;
    localparam logic [1:0]  EXCR_SW_RESET  = 2'h0;

    // Size of one instruction, for the delay-slot step back
    localparam logic [31:0] EXCR_INSN_BYTES = 32'h0000_0004;

    // Exception codes
    typedef enum logic [3:0] {
        EXCR_CODE_INT                   = 4'h0,
        EXCR_CODE_XLATE_MODIFY          = 4'h1,
        EXCR_CODE_XLATE_MISS_LOAD       = 4'h2,
        EXCR_CODE_XLATE_MISS_STORE      = 4'h3,
        EXCR_CODE_ADDR_ERR_LOAD         = 4'h4,
        EXCR_CODE_ADDR_ERR_STORE        = 4'h5,
        EXCR_CODE_FETCH_BUS_ERR         = 4'h6,
        EXCR_CODE_DATA_BUS_ERR          = 4'h7,
        EXCR_CODE_SYSCALL               = 4'h8,
        EXCR_CODE_BREAKPOINT            = 4'h9,
        EXCR_CODE_ILLEGAL_INSTR         = 4'ha,
        EXCR_CODE_COPROC_UNUSABLE       = 4'hb
    } excr_code_t;

    // Board interrupt request lines
    typedef struct packed {
        logic fpu_req;
        logic halt_req;
        logic power_fail_req;
        logic memory_error_req;
        logic write_error_req;
        logic tick_100hz_req;
        logic bus_level7_req;
        logic storage_port_req;
        logic network_port_req;
        logic bus_level6_req;
        logic bus_level5_req;
        logic console_req;
        logic timer_req;
        logic bus_level4_req;
    } excr_irq_src_t;

    localparam int EXCR_SRC_W = 14;

    // Exception taken by the pipeline
    typedef struct packed {
        logic       take;
        excr_code_t code;
        logic       in_delay;
        logic [31:0] pc;
    } excr_exc_t;

    // All state of the top module
    typedef struct packed {
        logic [1:0]  soft_irq_pending;
        excr_code_t  exc_code;
        logic        in_delay_slot;
        logic [31:0] exc_return_pc;
        logic [31:0] proc_status_reg;
        logic [31:0] rdata;
        logic [2:0]  top_line;
        logic        top_valid;
    } excr_state_t;

endpackage : excr_pkg

// [design/excr_sync.sv]
// Three-stage synchroniser with agreement filter for board request pins
`timescale 1ns/1ns
module excr_sync
    import excr_pkg::*;
#(
    parameter int W = EXCR_SRC_W
)(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    // Whole state of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } excr_sync_t;

    excr_sync_t st_q;    // Registered state
    excr_sync_t st_d;    // Next state

    // Shift stages; s1 feeds only s2 to limit metastability spread
    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++)
        begin
            // Accept a change only when two later stages agree
            if (st_q.s2[i] == st_q.s3[i])
            begin
                st_d.out[i] = st_q.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.out;

endmodule : excr_sync

// [design/excr_irq_map.sv]
// Maps board request lines onto pending bits and picks the top line
`timescale 1ns/1ns
module excr_irq_map
    import excr_pkg::*;
(
    input  wire excr_irq_src_t src,
    input  wire logic [5:0]    mask,
    output logic      [5:0]    pending,
    output logic      [2:0]    top_line,
    output logic               top_valid
);

    logic [5:0] raw;    // Unmasked line levels

    // Rank of line: halt, fpu, errors, then 2, 1, 0
    function automatic logic [2:0] excr_pick(input logic [5:0] p);
        logic [2:0] r;
        r = 3'h0;
        if (p[4])
            r = 3'h4;
        else if (p[5])
            r = 3'h5;
        else if (p[3])
            r = 3'h3;
        else if (p[2])
            r = 3'h2;
        else if (p[1])
            r = 3'h1;
        return r;
    endfunction : excr_pick

    // Merge sources sharing a line
    always_comb
    begin
        raw[5] = src.fpu_req;
        raw[4] = src.halt_req;
        raw[3] = src.power_fail_req | src.memory_error_req
               | src.write_error_req;
        raw[2] = src.tick_100hz_req | src.bus_level7_req;
        raw[1] = src.storage_port_req | src.network_port_req
               | src.bus_level6_req;
        raw[0] = src.bus_level5_req | src.console_req
               | src.timer_req | src.bus_level4_req;
    end

    // Only enabled lines become pending
    assign pending   = raw & mask;
    assign top_valid = |pending;
    assign top_line  = excr_pick(pending);

endmodule : excr_irq_map

// [design/excr_top.sv]
// Exception cause, return address and interrupt record for the core
//
// Function
// - Cause 15:10 shows pending hardware interrupts
// - Cause 9:8 are read/write software interrupts
// - Cause 7:6 and 1:0 read zero
// - Cause 5:2 hold last exception code
// - Codes 0-3: interrupt, modify, misses
// - Codes 4-7: address and bus errors
// - Codes 8-11: syscall, breakpoint, illegal, coprocessor
// - Fixed priority: halt, fpu, errors, 2,1,0
// - Sources merge onto lines; vector levels 7-4
// - Return pc takes faulting instruction address
// - Delay slot: return pc is branch address
// - Provide 32-bit processor status register
// - Cause bit 31 flags delay-slot exception
// - Only software bits of cause are writable
// - Pending needs matching status mask bit set
`timescale 1ns/1ns

// How the block behaves, in brief
// Register port
// Every strobe is answered at once
// There are no wait states, so no ready line
// Read data stands one cycle, then reads zero
// Unmapped offsets read zero and ignore writes
// A read beside a write sees the old value
// Cause word
// Assembled on each read, not stored whole
// Only the software bits and the record are stored
// Pending bits are live lines, never latched
// So software sees a request drop at once
// Spare and coprocessor bits always read zero
// Writes touch the software bits only
// Exception record
// Written on the cycle a take is presented
// Code, delay flag and return pc move as one
// A take on every cycle simply overwrites
// Nothing is queued; the last take wins
// In a delay slot the pc steps back one word
// Limitation: no check that pc is word aligned
// Status register
// Holds line masks, soft masks and enables
// Reserved bits are forced to zero on write
// Reset clears it, so all masks start off
// Request pins
// They come from other clock domains
// Each passes four flip-flops before use
// A change counts once two late stages agree
// Trade-off: four cycles of latency for margin
// Glitches of one cycle never reach the pending bits
// Priority report
// Registered, one cycle behind the pending bits
// Dispatch code must allow for that cycle
// Halt ranks above the float unit line
// Then errors, then the three shared lines
// Vector reads
// Acknowledge is a one-cycle combinational pulse
// It starts the chain at the chosen level only
// The chain itself lives with the sources
// Hazard: no response detection here
// A silent chain returns whatever the bus shows
// Interrupt request
// Any enabled line or soft bit, when enabled
// Gated by the current enable bit of status
// Purely combinational from registered state
// Hazard: callers must not sample it mid-write
// Clocking
// One clock, no enable; every flop runs always
// Reset is asynchronous and active low
// Only constants are loaded under reset
// Things left to other blocks
// Status fields beyond masks and enables
// Address translation and its fault sources
// The vector read cycle on the peripheral bus
// The request sources themselves
module excr_top
    import excr_pkg::*;
(
    // Clock and reset
    input  wire logic          CORE_CLK,
    input  wire logic          RESET_N,
    // Register port
    input  wire logic [7:0]    REG_ADDR,
    input  wire logic [31:0]   REG_WDATA,
    input  wire logic          REG_WR,
    input  wire logic          REG_RD,
    output logic      [31:0]   REG_RDATA,
    // Exception taken by the pipeline
    input  wire excr_exc_t     EXC_IN,
    // Board requests and vector bus
    input  wire excr_irq_src_t IRQ_SRC,
    input  wire logic [15:0]   VECTOR_DATA,
    output logic      [3:0]    VECTOR_ACK,
    // Interrupt status towards the core
    output logic      [5:0]    HW_IRQ_PENDING,
    output logic      [1:0]    SOFT_IRQ_PENDING,
    output logic               IRQ_REQUEST,
    output logic      [2:0]    IRQ_TOP_LINE,
    output logic               IRQ_TOP_VALID
);

    // Record state and its next value
    excr_state_t   st_q;       // Registered state
    excr_state_t   st_d;       // Next state
    // Interrupt path
    excr_irq_src_t src_sync;   // Request lines after synchroniser
    logic [5:0]    ip_live;    // Masked pending lines, this cycle
    logic [2:0]    top_line;   // Highest ranked pending line
    logic          top_valid;  // Any line pending
    logic [31:0]   cause_word; // Cause as software reads it
    // Address decode results
    logic          sel_cause;  // Address hits cause
    logic          sel_status; // Address hits status
    logic          sel_epc;    // Address hits return pc
    logic [3:0]    sel_vec;    // Address hits a vector read register
    logic          soft_live;  // Enabled software interrupt

    // Request pins come from other domains, so filter them
    excr_sync #(
        .W    (EXCR_SRC_W)
    ) u_sync (
        .clk  (CORE_CLK),
        .rst_n(RESET_N),
        .din  (IRQ_SRC),
        .dout (src_sync)
    );

    // Merge and rank lines, gated by the status mask
    excr_irq_map u_map (
        .src      (src_sync),
        .mask     (st_q.proc_status_reg[EXCR_SR_MASK_LO +: 6]),
        .pending  (ip_live),
        .top_line (top_line),
        .top_valid(top_valid)
    );

    // Offset match; one helper keeps every decode alike
    function automatic logic excr_hit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return addr == ofs;
    endfunction : excr_hit

    // Address decode, shared by read and write paths
    always_comb
    begin
        // Full compare, so aliases never hit
        sel_cause  = excr_hit(REG_ADDR, EXCR_OFS_CAUSE);
        sel_status = excr_hit(REG_ADDR, EXCR_OFS_STATUS);
        sel_epc    = excr_hit(REG_ADDR, EXCR_OFS_EPC);
    end

    // One select per vector read register, one word apart
    for (genvar v = 0; v < 4; v++)
    begin : g_vec
        // Lowest level at the lowest offset
        assign sel_vec[v] = excr_hit(REG_ADDR, EXCR_OFS_VEC0 + 8'(4 * v));
    end

    // Cause word assembly; unused bits tie to zero
    always_comb
    begin
        cause_word = '0;
        cause_word[EXCR_BD_POS] = st_q.in_delay_slot;
        // Live lines, not a snapshot, so software sees them drop
        cause_word[EXCR_IP_LO +: 6] = ip_live;
        cause_word[EXCR_SW_LO +: 2] = st_q.soft_irq_pending;
        cause_word[EXCR_EC_LO +: 4] = st_q.exc_code;
    end

    // Software interrupt counts only when its mask bit is set
    assign soft_live = |(st_q.soft_irq_pending
                       & st_q.proc_status_reg[EXCR_SR_SWM_LO +: 2]);

    // Ordering inside the next-state logic
    // Read data is picked first, from old state
    // Writes come next; cause and status only
    // The exception record is written last
    // Record fields and software bits differ,
    // So a take never races a cause write
    // Priority report samples live lines last
    // Next-state logic for the whole record
    always_comb
    begin
        st_d = st_q;

        // Read data stands for one cycle only; idle returns zero
        st_d.rdata = '0;
        if (REG_RD)
        begin
            if (sel_cause)
            begin
                st_d.rdata = cause_word;
            end
            else if (sel_status)
            begin
                st_d.rdata = st_q.proc_status_reg;
            end
            else if (sel_epc)
            begin
                st_d.rdata = st_q.exc_return_pc;
            end
            else if (|sel_vec)
            begin
                // Vector comes back from the acknowledged source
                st_d.rdata = {16'h0000, VECTOR_DATA};
            end
            else
            begin
                // Unmapped address reads as zero
                st_d.rdata = '0;
            end
        end

        // Register writes
        if (REG_WR)
        begin
            if (sel_cause)
            begin
                // Everything but the software bits is ignored
                st_d.soft_irq_pending =
                    REG_WDATA[EXCR_SW_LO +: 2];
            end
            else if (sel_status)
            begin
                // Reserved status bits stay zero
                st_d.proc_status_reg =
                    REG_WDATA & EXCR_SR_WR_MASK;
            end
            else
            begin
                // Return pc and vector registers are read only
                st_d.soft_irq_pending = st_q.soft_irq_pending;
            end
        end

        // Exception record: code, flag and pc move as one
        if (EXC_IN.take)
        begin
            st_d.exc_code      = EXC_IN.code;
            st_d.in_delay_slot = EXC_IN.in_delay;
            if (EXC_IN.in_delay)
            begin
                // Step back one word to the branch or jump
                st_d.exc_return_pc =
                    EXC_IN.pc - EXCR_INSN_BYTES;
            end
            else
            begin
                st_d.exc_return_pc = EXC_IN.pc;
            end
        end

        // Registered priority report, for the handler dispatch
        st_d.top_line  = top_line;
        st_d.top_valid = top_valid;
    end

    // Reset leaves every mask and enable off,
    // So no interrupt escapes before software
    // Has set up the status register
    // State register; constants only under reset
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            st_q.soft_irq_pending <= EXCR_SW_RESET;
            st_q.exc_code         <= EXCR_CODE_INT;
            st_q.in_delay_slot    <= 1'b0;
            st_q.exc_return_pc    <= EXCR_EPC_RESET;
            st_q.proc_status_reg  <= EXCR_SR_RESET;
            st_q.rdata            <= '0;
            st_q.top_line         <= 3'h0;
            st_q.top_valid        <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Vector read acknowledge: one pulse per read, combinational.
    // The sources on a shared line pass it along their own chain;
    // this block only starts it at the right level.
    assign VECTOR_ACK = REG_RD ? sel_vec : 4'h0;

    // Pending and request follow a mask write
    // In the very next cycle; the priority
    // Report lags them by one cycle more
    // Outputs
    assign REG_RDATA        = st_q.rdata;
    assign HW_IRQ_PENDING   = ip_live;
    assign SOFT_IRQ_PENDING = st_q.soft_irq_pending;
    assign IRQ_TOP_LINE     = st_q.top_line;
    assign IRQ_TOP_VALID    = st_q.top_valid;

    // Core interrupt request, gated by the current enable
    assign IRQ_REQUEST = (|ip_live | soft_live)
                       & st_q.proc_status_reg[EXCR_SR_IEC_POS];

endmodule : excr_top

// [testbench/excr_top_properties.sv]
// Concurrent checks on the exception record top-level ports
`timescale 1ns/1ns
module excr_top_checker
    import excr_pkg::*;
(
    input wire logic          CORE_CLK,
    input wire logic          RESET_N,
    input wire logic [7:0]    REG_ADDR,
    input wire logic [31:0]   REG_WDATA,
    input wire logic          REG_WR,
    input wire logic          REG_RD,
    input wire logic [31:0]   REG_RDATA,
    input wire excr_exc_t     EXC_IN,
    input wire excr_irq_src_t IRQ_SRC,
    input wire logic [15:0]   VECTOR_DATA,
    input wire logic [3:0]    VECTOR_ACK,
    input wire logic [5:0]    HW_IRQ_PENDING,
    input wire logic [1:0]    SOFT_IRQ_PENDING,
    input wire logic          IRQ_REQUEST,
    input wire logic [2:0]    IRQ_TOP_LINE,
    input wire logic          IRQ_TOP_VALID
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // Cause read, unused fields
    property p_zero; REG_RD && REG_ADDR == EXCR_OFS_CAUSE |=> REG_RDATA[7:6] == 2'h0
        && REG_RDATA[1:0] == 2'h0 && REG_RDATA[30:16] == 15'h0; endproperty
    a_zero: assert property (p_zero) else $error("cause spare bits not zero");
    // Cause read shows the live pending bits
    property p_pend; REG_RD && REG_ADDR == EXCR_OFS_CAUSE |=> REG_RDATA[15:10] ==
        $past(HW_IRQ_PENDING) && REG_RDATA[9:8] == $past(SOFT_IRQ_PENDING); endproperty
    a_pend: assert property (p_pend) else $error("cause pending bits wrong");
    // Exception record visible to a read on the next cycle
    property p_rec; EXC_IN.take ##1 (REG_RD && REG_ADDR == EXCR_OFS_CAUSE && !EXC_IN.take)
        |=> REG_RDATA[5:2] == $past(EXC_IN.code, 2)
        && REG_RDATA[31] == $past(EXC_IN.in_delay, 2); endproperty
    a_rec: assert property (p_rec) else $error("code or delay flag wrong");
    // Return address steps back over the branch in a delay slot
    property p_epc; EXC_IN.take ##1 (REG_RD && REG_ADDR == EXCR_OFS_EPC && !EXC_IN.take)
        |=> REG_RDATA == ($past(EXC_IN.in_delay, 2) ? $past(EXC_IN.pc, 2) - EXCR_INSN_BYTES
        : $past(EXC_IN.pc, 2)); endproperty
    a_epc: assert property (p_epc) else $error("return address wrong");
    // The software bits take a cause write
    property p_swr; REG_WR && REG_ADDR == EXCR_OFS_CAUSE |=>
        SOFT_IRQ_PENDING == $past(REG_WDATA[9:8]); endproperty
    a_swr: assert property (p_swr) else $error("software bits not written");
    // Halt outranks everything
    property p_halt; HW_IRQ_PENDING[4] |=> IRQ_TOP_LINE == 3'h4 && IRQ_TOP_VALID; endproperty
    a_halt: assert property (p_halt) else $error("halt not on top");
    // Float unit second
    property p_fpu; HW_IRQ_PENDING[5] && !HW_IRQ_PENDING[4] |=> IRQ_TOP_LINE == 3'h5;
    endproperty
    a_fpu: assert property (p_fpu) else $error("float line not second");
    // Nothing pending, no top line
    property p_idle; HW_IRQ_PENDING == 6'h0 |=> !IRQ_TOP_VALID; endproperty
    a_idle: assert property (p_idle) else $error("top valid without pending");
    // Highest vector level acknowledged in the read cycle
    property p_ack; REG_RD && REG_ADDR == EXCR_OFS_VEC3 |-> VECTOR_ACK == 4'h8; endproperty
    a_ack: assert property (p_ack) else $error("vector acknowledge wrong");
    // Vector returned in the low half
    property p_vec; REG_RD && REG_ADDR[7:4] == 4'h1 && REG_ADDR[1:0] == 2'h0 |=>
        REG_RDATA == {16'h0, $past(VECTOR_DATA)}; endproperty
    a_vec: assert property (p_vec) else $error("vector data wrong");
    c_slot: cover property (EXC_IN.take && EXC_IN.in_delay);
    c_fpu: cover property (HW_IRQ_PENDING[5] && !HW_IRQ_PENDING[4]);
    c_vec: cover property (REG_RD && REG_ADDR == EXCR_OFS_VEC0);
endmodule : excr_top_checker
bind excr_top excr_top_checker u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .EXC_IN(EXC_IN), .IRQ_SRC(IRQ_SRC), .VECTOR_DATA(VECTOR_DATA),
    .VECTOR_ACK(VECTOR_ACK), .HW_IRQ_PENDING(HW_IRQ_PENDING),
    .SOFT_IRQ_PENDING(SOFT_IRQ_PENDING), .IRQ_REQUEST(IRQ_REQUEST),
    .IRQ_TOP_LINE(IRQ_TOP_LINE), .IRQ_TOP_VALID(IRQ_TOP_VALID));

// [testbench/excr_src_model.sv]
// Board interrupt sources with acknowledge chains
`timescale 1ns/1ns
module excr_src_model
    import excr_pkg::*;
(
    input  wire logic          clk,
    input  wire excr_irq_src_t req,
    input  wire logic [3:0]    ack,
    output excr_irq_src_t      src,
    output logic [15:0]        vec
);
    logic [15:0] last_q; // Last vector seen on the bus
    logic [15:0] pick;   // Answer of the chain
    logic [13:0] r;      // Requests as bits
    int          lo;     // Chain span, low end
    int          hi;     // Chain span, high end
    assign src = req;
    assign r = req;
    assign vec = pick;
    // Highest-numbered requester in the acknowledged span answers
    always_comb
    begin
        lo = ack[3] ? 7 : ack[2] ? 4 : 0;
        hi = ack[3] ? 8 : ack[2] ? 6 : 3;
        // Released bus shows no stale vector
        pick = ~last_q;
        for (int i = 0; i < 9; i++)
            if (|ack && i >= lo && i <= hi && r[i]) pick = 16'h0100 + 16'(i);
    end
    // Remember for the floating pattern
    always_ff @(posedge clk) last_q <= vec;
endmodule : excr_src_model

// [testbench/test_exception_cause_and_interrupt_record.sv]
// Self-checking bench for the exception record block
`timescale 1ns/1ns
module test_exception_cause_and_interrupt_record
    import excr_pkg::*;
;
    logic          clk, rst_n, wr, rd, irq, topv;
    logic [7:0]    addr;
    logic [31:0]   wdata, rdata, r;
    excr_exc_t     exc;
    excr_irq_src_t req, src;
    logic [15:0]   vdata;
    logic [3:0]    ack;
    logic [5:0]    hwp;
    logic [1:0]    swp;
    logic [2:0]    top;
    int            n_errors, num_checks;
    excr_top u_dut (.CORE_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .EXC_IN(exc), .IRQ_SRC(src),
        .VECTOR_DATA(vdata), .VECTOR_ACK(ack), .HW_IRQ_PENDING(hwp),
        .SOFT_IRQ_PENDING(swp), .IRQ_REQUEST(irq), .IRQ_TOP_LINE(top), .IRQ_TOP_VALID(topv));
    excr_src_model u_src (.clk(clk), .req(req), .ack(ack), .src(src), .vec(vdata));
    always #2 clk = ~clk;
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 r = rdata;
    endtask : rd_reg
    // Exception taken, then a read on the very next cycle
    task automatic take(int c, logic d, logic [31:0] pc, logic [7:0] a);
        @(posedge clk);
        exc <= '{take: 1'b1, code: excr_code_t'(c), in_delay: d, pc: pc};
        @(posedge clk);
        exc.take <= 1'b0;
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 r = rdata;
    endtask : take
    function automatic int line_of(int i);
        return i < 4 ? 0 : i < 7 ? 1 : i < 9 ? 2 : i < 12 ? 3 : i == 12 ? 4 : 5;
    endfunction : line_of
    task automatic t_codes();
        logic [31:0] pc;
        for (int c = 0; c < 12; c++)
        begin
            pc = 32'h2000 + 32'(c * 16);
            take(c, c[0], pc, EXCR_OFS_CAUSE);
            check("cause", r, {c[0], 25'h0, 4'(c), 2'h0});
            take(c, c[0], pc, EXCR_OFS_EPC);
            check("epc", r, c[0] ? pc - 32'h4 : pc);
        end
    endtask : t_codes
    task automatic t_soft();
        wr_reg(EXCR_OFS_CAUSE, 32'hffffffff);
        rd_reg(EXCR_OFS_CAUSE);
        check("cause after write", r, 32'h8000_032c);
        check("soft pins", 32'(swp), 32'h3);
        wr_reg(EXCR_OFS_STATUS, 32'h0000_0301);
        check("soft request", 32'(irq), 32'h1);
        wr_reg(EXCR_OFS_STATUS, 32'h0);
        check("soft gated", 32'(irq), 32'h0);
        wr_reg(EXCR_OFS_CAUSE, 32'h0);
        check("soft cleared", 32'(swp), 32'h0);
    endtask : t_soft
    // Each source lands on the pending line it shares
    task automatic t_map();
        wr_reg(EXCR_OFS_STATUS, 32'h0000_fc00);
        for (int i = 0; i < 14; i++)
        begin
            @(posedge clk);
            req <= excr_irq_src_t'(14'h1 << i);
            repeat (6) @(posedge clk);
            #1 check("pending", 32'(hwp), 32'(6'h1 << line_of(i)));
        end
    endtask : t_map
    task automatic t_prio();
        logic [13:0] m [6] = '{14'h3fff, 14'h2fff, 14'h0fff, 14'h01ff, 14'h007f, 14'h000f};
        logic [2:0]  e [6] = '{3'h4, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0};
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk);
            req <= excr_irq_src_t'(m[k]);
            repeat (6) @(posedge clk);
            #1 check("top line", 32'(top), 32'(e[k]));
        end
        check("top valid", 32'(topv), 32'h1);
        check("no enable", 32'(irq), 32'h0);
        wr_reg(EXCR_OFS_STATUS, 32'h0000_fc01);
        check("hw request", 32'(irq), 32'h1);
        wr_reg(EXCR_OFS_STATUS, 32'h0);
        check("masked pending", 32'(hwp), 32'h0);
        rd_reg(EXCR_OFS_CAUSE);
        check("masked cause", 32'(r[15:10]), 32'h0);
    endtask : t_prio
    // Vector reads, all sources requesting
    task automatic t_vec();
        logic [15:0] e;
        @(posedge clk);
        req <= excr_irq_src_t'(14'h3fff);
        for (int n = 0; n < 4; n++)
        begin
            e = n == 3 ? 16'h0108 : n == 2 ? 16'h0106 : 16'h0103;
            rd_reg(8'h10 + 8'(4 * n));
            check("vector", r, {16'h0, e});
        end
    endtask : t_vec
    task automatic summarize();
        if (n_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    // Cut a hang short
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        summarize();
    end
    initial
    begin
        {clk, rst_n, wr, rd, addr, wdata, exc, req} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(EXCR_OFS_STATUS);
        check("status reset", r, 32'h0);
        rd_reg(EXCR_OFS_CAUSE);
        check("cause reset", r, 32'h0);
        wr_reg(EXCR_OFS_STATUS, 32'hffffffff);
        rd_reg(EXCR_OFS_STATUS);
        check("status", r, EXCR_SR_WR_MASK);
        wr_reg(EXCR_OFS_STATUS, 32'h0);
        t_codes();
        t_soft();
        t_map();
        t_prio();
        t_vec();
        summarize();
    end
endmodule : test_exception_cause_and_interrupt_record
